// File: dv/spfp_core_checker.sv
// Port checker of the serial port core.
// Assumes a bind onto spfp_core.
`timescale 1ns/10ps
`default_nettype none
module spfp_core_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic device_idle,
    input wire spfp_pkg::spfp_pins_s pins,
    input wire logic port_active
);
    logic [15:0] sh [0:2];
    wire id = sh[0][13] && device_idle;
    wire fm = sh[2][15] && !sh[2][14] && sh[0][15];
    wire dk = sh[1][12] && sh[1][5];
    always_ff @(posedge clk) begin
        if (!rst_b) sh <= '{default: 16'h0000};
        else if (reg_wr && reg_addr != 2'h3) sh[reg_addr] <= reg_wdata;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_rst;
        disable iff (1'b0) !rst_b |=> pins.sck_oe_b && pins.sdo_oe_b && pins.ss_oe_b && pins.ss_o;
    endproperty
    property p_rdata; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
    property p_off;
        reg_wr && reg_addr == 2'h0 && !reg_wdata[15] |=> !port_active ##1 (pins.sck_oe_b && pins.sdo_oe_b);
    endproperty
    property p_idle; $past(id) && id |-> !port_active; endproperty
    property p_msb;
        reg_wr && reg_addr == 2'h3 && sh[0][15] && sh[1][5] && !sh[2][0]
        |=> ##1 pins.sdo_o == (sh[1][10] ? $past(reg_wdata[15], 2) : $past(reg_wdata[7], 2));
    endproperty
    property p_dsdo; $past(sh[1][11]) && sh[1][11] |-> pins.sdo_oe_b; endproperty
    property p_dsck; $past(dk) && dk |-> pins.sck_oe_b; endproperty
    property p_frm; $past(fm) && fm |-> !pins.ss_oe_b; endproperty
    a_rst: assert property (p_rst) else $error("pins driven after reset");
    a_rdata: assert property (p_rdata) else $error("read data outside read slot");
    a_off: assert property (p_off) else $error("port still active after disable");
    a_idle: assert property (p_idle) else $error("port runs in idle");
    a_msb: assert property (p_msb) else $error("first bit is not the top bit");
    a_dsdo: assert property (p_dsdo) else $error("out pin driven while released");
    a_dsck: assert property (p_dsck) else $error("clock pin driven while released");
    a_frm: assert property (p_frm) else $error("sync pin not driven as frame master");
    c_data: cover property (reg_wr && reg_addr == 2'h3);
    c_read: cover property (reg_rd && reg_addr == 2'h3);
    c_sync: cover property (!pins.ss_oe_b);
endmodule : spfp_core_checker
`default_nettype wire

// File: dv/spfp_partner.sv
// Far-side serial peripheral: echoes each received word on the next.
// Assumes output change on the trailing clock edge.
`timescale 1ns/10ps
`default_nettype none
module spfp_partner (
    input wire logic sck,
    input wire logic sdo,
    input wire logic en,
    input wire logic cpol,
    input wire logic wide,
    output logic sdi,
    output int bits,
    output logic [15:0] got,
    output logic [15:0] tx
);
    int n = 0;
    initial bits = 0;
    initial tx = 16'ha5c3;
    initial got = 16'h3c96;
    assign sdi = wide ? tx[15] : tx[7];
    always @(sck) begin
        if (en && sck !== cpol) begin
            got = {got[14:0], sdo};
            bits = bits + 1;
            n = n + 1;
        end else if (en && n != 0) begin
            tx = (n == (wide ? 16 : 8)) ? got : tx << 1;
            n = (n == (wide ? 16 : 8)) ? 0 : n;
        end
    end
endmodule : spfp_partner
`default_nettype wire

// File: dv/test_spfp_core.sv
// Testbench of the serial port core against an echoing peripheral.
// Assumes partner and checker compiled before it.
`timescale 1ns/10ps
`default_nettype none
module test_spfp_core;
    import spfp_pkg::*;
    logic clk = 0;
    logic rst_b = 0;
    logic [1:0] reg_addr = 2'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 0;
    logic reg_rd = 0;
    logic device_idle = 0;
    logic cpol = 0;
    logic wide = 0;
    logic sdi, port_active, buffer_event;
    logic [15:0] reg_rdata, v, c1, d, e, m, pgot, ptx;
    spfp_pins_s pins;
    int error_cnt = 0;
    int total_checks = 0;
    int seed = 32'h37d4;
    int cyc = 0;
    int pbits, n, w;
    time t0 = 0;
    time hp = 0;
    spfp_core spfp_core_i (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .device_idle(device_idle), .sck_i(1'b0), .sdi_i(sdi),
        .ss_i(1'b1), .pins(pins), .port_active(port_active), .buffer_event(buffer_event));
    spfp_partner spfp_partner_i (.sck(pins.sck_o), .sdo(pins.sdo_o), .en(port_active), .cpol(cpol), .wide(wide),
        .sdi(sdi), .bits(pbits), .got(pgot), .tx(ptx));
    initial forever #2.5 clk = ~clk;
    always @(pins.sck_o) begin
        hp = $time - t0;
        t0 = $time;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            error_cnt++;
            finish_test();
        end
    end
    function automatic int ratio(logic [15:0] c);
        return (c[1:0] == 2'b11 ? 1 : c[1:0] == 2'b10 ? 4 : c[1:0] == 2'b01 ? 16 : 64) * (8 - c[4:2]);
    endfunction : ratio
    task automatic chk(input string s, input logic [15:0] seen, input logic [15:0] x);
        total_checks++;
        if (seen !== x) begin
            $display("CHECK FAILED %s expected %h seen %h", s, x, seen);
            error_cnt++;
        end
    endtask : chk
    task automatic wr(input logic [1:0] a, input logic [15:0] x);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= x;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] a, output logic [15:0] x);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        x = reg_rdata;
    endtask : rd
    // Bits counted by the peripheral, then the last half bit settles
    task automatic wt(input int b);
        for (int i = 0; i < 40000 && pbits < b; i++) @(posedge clk);
        repeat (80) @(posedge clk);
    endtask : wt
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        rd(2'h1, v);
        chk("ctl1", v, 16'h0000);
        rd(2'h2, v);
        chk("ctl2", v, 16'h0000);
        rd(2'h0, v);
        chk("stat", v & 16'hff43, 16'h0000);
        for (int k = 0; k < 5; k++) begin
            wide = k[0];
            w = wide ? 16 : 8;
            m = wide ? 16'hffff : 16'h00ff;
            d = 16'($random(seed));
            cpol = d[8];
            c1 = {5'h00, wide, 2'b01, 1'b0, d[8], 1'b1, 1'b0, d[10:9], ~d[11], d[11]};
            wr(2'h0, 16'h0000);
            wr(2'h1, c1);
            wr(2'h0, 16'h8000);
            repeat (4) @(posedge clk);
            e = ptx & m;
            n = pbits;
            d = (k == 4) ? 16'hffff : 16'($random(seed));
            wr(2'h3, d);
            wt(n + w);
            chk("sent", pgot & m, d & m);
            chk("pulses", 16'(pbits - n), 16'(w));
            chk("idle", 16'(pins.sck_o), 16'(cpol));
            chk("half", 16'(hp), 16'(ratio(c1) * 5 / 2));
            rd(2'h0, v);
            chk("rbf", 16'(v[0]), 16'h0001);
            rd(2'h3, v);
            chk("rx", v, e);
            rd(2'h0, v);
            chk("rbf0", 16'(v[0]), 16'h0000);
        end
        e = ptx & m;
        n = pbits;
        wr(2'h3, d);
        wt(n + w);
        wr(2'h3, ~d);
        wt(n + 2 * w);
        rd(2'h0, v);
        chk("ovf", 16'(v[6]), 16'h0001);
        rd(2'h3, v);
        chk("kept", v, e);
        wr(2'h0, 16'h8000);
        rd(2'h0, v);
        chk("ovf0", 16'(v[6]), 16'h0000);
        wr(2'h0, 16'ha000);
        device_idle <= 1'b1;
        repeat (3) @(posedge clk);
        chk("stop", 16'(port_active), 16'h0000);
        device_idle <= 1'b0;
        repeat (3) @(posedge clk);
        chk("run", 16'(port_active), 16'h0001);
        wr(2'h0, 16'h0000);
        wr(2'h2, 16'h0001);
        wr(2'h0, 16'h801c);
        n = pbits;
        for (int k = 0; k < 9; k++) wr(2'h3, 16'($random(seed)));
        rd(2'h0, v);
        chk("tbf", 16'(v[1]), 16'h0001);
        chk("event", 16'(buffer_event), 16'h0001);
        wt(n + 9 * w);
        rd(2'h0, v);
        chk("flags", v & 16'h00a1, 16'h0081);
        for (int k = 0; k < 8; k++) rd(2'h3, v);
        rd(2'h0, v);
        chk("empty", 16'(v[5]), 16'h0001);
        wr(2'h0, 16'h0000);
        wr(2'h2, 16'h8000);
        wr(2'h1, 16'h1820);
        wr(2'h0, 16'h8000);
        repeat (4) @(posedge clk);
        chk("sync", 16'(pins.ss_oe_b), 16'h0000);
        chk("sdo_off", 16'(pins.sdo_oe_b), 16'h0001);
        finish_test();
    end
endmodule : test_spfp_core
bind spfp_core spfp_core_checker spfp_core_checker_i (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .device_idle(device_idle),
    .pins(pins), .port_active(port_active));
`default_nettype wire

// File: logic/spfp_core.sv
// Framed serial port: register file, prescaler, shifter, buffers, pin drive.
// Assumes synchronous register port; pins come from outside and are synchronised here.
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "spfp_params.svh"
module spfp_core #(
    parameter int DEPTH = `SPFP_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [`SPFP_ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic device_idle,
    input wire logic sck_i,
    input wire logic sdi_i,
    input wire logic ss_i,
    output spfp_pkg::spfp_pins_s pins,
    output logic port_active,
    output logic buffer_event
);
    import spfp_pkg::*;
    localparam int CW = $clog2(DEPTH) + 1;

    spfp_ctl1_s ctl1, next_ctl1;
    spfp_ctl2_s ctl2, next_ctl2;
    logic port_enable, next_port_enable, stop_in_idle, next_stop_in_idle;
    logic receive_overflow_flag, next_receive_overflow_flag;
    logic [2:0] buffer_irq_select, next_buffer_irq_select;
    logic [15:0] tx_holding_register, next_tx_holding_register;
    logic [15:0] rx_holding_register, next_rx_holding_register;
    logic std_tx_full, next_std_tx_full, std_rx_full, next_std_rx_full;
    spfp_state_e state, next_state;
    logic [15:0] shift_register, next_shift_register;
    logic [4:0] bits_left, next_bits_left;
    logic sck_lvl, next_sck_lvl, sdo_lvl, next_sdo_lvl, fs_lvl, next_fs_lvl;
    logic [`SPFP_PRE_W-1:0] pre_cnt, next_pre_cnt;
    logic half_tick;
    logic rx_done, tx_load;
    logic [2:0] sck_sync, sdi_sync, ss_sync;
    logic shift_done_q, load_q;
    logic [15:0] rd_data_q, next_rd_data_q;

    // Pin synchronisers; only stage 1 and later are read
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sck_sync <= 3'h0;
            sdi_sync <= 3'h0;
            ss_sync <= 3'h7;
        end else begin
            sck_sync <= {sck_sync[1:0], sck_i};
            sdi_sync <= {sdi_sync[1:0], sdi_i};
            ss_sync <= {ss_sync[1:0], ss_i};
        end
    end

    logic enh, master, framed, running, wide, cke_eff;
    logic data_wr, data_rd;
    logic [CW-1:0] txf_count, rxf_count;
    logic [15:0] txf_head, rxf_head;
    logic ss_active, fs_in_active, ext_lead, ext_trail;
    assign enh = ctl2.enhanced_buffer_enable;
    assign master = ctl1.master_select;
    assign framed = ctl2.framed_enable;
    assign wide = ctl1.word_width_select;
    assign cke_eff = ctl1.clock_edge && !framed;
    assign running = port_enable && !(stop_in_idle && device_idle);
    assign data_wr = reg_wr && reg_addr == `SPFP_REG_DATA;
    assign data_rd = reg_rd && reg_addr == `SPFP_REG_DATA;

    // Divide ratio: primary 64,16,4,1 times secondary 8..1
    function automatic logic [`SPFP_PRE_W-1:0] div_ratio(input logic [2:0] sec, input logic [1:0] pri);
        logic [`SPFP_PRE_W-1:0] s;
        s = `SPFP_PRE_W'(4'h8 - {1'b0, sec});
        div_ratio = s << (4'h6 - {2'b00, pri, 1'b0});
    endfunction : div_ratio

    // Half-bit tick: sck toggles every ratio/2 clocks, ratio 1 uses every clock
    logic [`SPFP_PRE_W-1:0] ratio, half;
    assign ratio = div_ratio(ctl1.secondary_prescale, ctl1.primary_prescale);
    assign half = (ratio > `SPFP_PRE_W'(1)) ? (ratio >> 1) : `SPFP_PRE_W'(1);
    assign half_tick = (pre_cnt == half - `SPFP_PRE_W'(1));

    always_comb begin
        next_pre_cnt = (state == SPFP_IDLE || half_tick) ? '0 : pre_cnt + `SPFP_PRE_W'(1);
    end

    // External clock edges for slave mode
    logic sck_rise, sck_fall, sck_lead, sck_trail;
    assign sck_rise = sck_sync[1] && !sck_sync[2];
    assign sck_fall = !sck_sync[1] && sck_sync[2];
    assign sck_lead = ctl1.clock_polarity ? sck_fall : sck_rise;
    assign sck_trail = ctl1.clock_polarity ? sck_rise : sck_fall;
    assign fs_in_active = (ss_sync[1] == ctl2.frame_sync_polarity);
    // Slave select gates slave; framed slave uses frame sync
    assign ss_active = !ctl1.select_pin_enable || !ss_sync[1];
    assign ext_lead = sck_lead && ss_active;
    assign ext_trail = sck_trail && ss_active;

    // Transmit and receive buffers
    logic tx_push, tx_pop, rx_push, rx_pop, txf_full, rxf_full;
    assign txf_full = txf_count == CW'(DEPTH);
    assign rxf_full = rxf_count == CW'(DEPTH);
    assign tx_push = enh && data_wr && !txf_full;
    assign tx_pop = enh && tx_load;
    assign rx_pop = enh && data_rd;
    assign rx_push = enh && rx_done && !rxf_full;

    spfp_fifo #(.WIDTH(16), .DEPTH(DEPTH)) u_txf (
        .clk(clk), .rst_b(rst_b), .flush(!port_enable || !enh), .push(tx_push),
        .push_data(reg_wdata), .pop(tx_pop), .head(txf_head), .count(txf_count)
    );
    spfp_fifo #(.WIDTH(16), .DEPTH(DEPTH)) u_rxf (
        .clk(clk), .rst_b(rst_b), .flush(!port_enable || !enh), .push(rx_push),
        .push_data(shift_register), .pop(rx_pop), .head(rxf_head), .count(rxf_count)
    );

    logic tx_avail;
    assign tx_avail = enh ? (txf_count != '0) : std_tx_full;
    // Word is loaded when idle and data waits; slave preloads likewise
    assign tx_load = running && state == SPFP_IDLE && tx_avail;

    // Shifter state machine
    logic lead_edge, samp_lead;
    assign lead_edge = master ? (sck_lvl == ctl1.clock_polarity) : ext_lead;
    // Output on the leading edge puts both sample points on the trailing edge
    assign samp_lead = cke_eff && !(master && ctl1.sample_phase);
    always_comb begin
        next_state = state;
        next_shift_register = shift_register;
        next_bits_left = bits_left;
        next_sck_lvl = sck_lvl;
        next_sdo_lvl = sdo_lvl;
        next_fs_lvl = fs_lvl;
        rx_done = 1'b0;
        if (!running) begin
            next_state = SPFP_IDLE;
            next_sck_lvl = ctl1.clock_polarity;
            next_fs_lvl = 1'b0;
        end else begin
            case (state)
                SPFP_IDLE: begin
                    next_sck_lvl = ctl1.clock_polarity;
                    if (tx_load || (!master && ss_active && !(framed && ctl2.frame_sync_direction))) begin
                        if (tx_load) begin
                            next_shift_register = enh ? txf_head : tx_holding_register;
                            next_sdo_lvl = wide ? next_shift_register[15] : next_shift_register[7];
                        end
                        next_bits_left = wide ? 5'h10 : 5'h08;
                        if (tx_load || !master) begin
                            next_state = (framed && !ctl2.frame_sync_edge) ? SPFP_SYNC : SPFP_SHIFT;
                            next_fs_lvl = framed && !ctl2.frame_sync_direction;
                        end
                        if (!master && !tx_load && !framed) begin
                            next_state = SPFP_IDLE;
                        end
                    end
                    if (!master && framed && ctl2.frame_sync_direction && fs_in_active) begin
                        next_bits_left = wide ? 5'h10 : 5'h08;
                        next_state = SPFP_SHIFT;
                    end
                end
                SPFP_SYNC: begin
                    // Sync stands a half bit with the clock idle, then shifting starts
                    if (master ? half_tick : ext_trail) begin
                        next_state = SPFP_SHIFT;
                    end
                end
                SPFP_SHIFT: begin
                    if (master ? half_tick : (ext_lead || ext_trail)) begin
                        if (master) begin
                            next_sck_lvl = !sck_lvl;
                        end
                        if (lead_edge != ctl2.frame_sync_edge) begin
                            next_fs_lvl = 1'b0;
                        end
                        if (lead_edge == samp_lead) begin
                            next_shift_register = {shift_register[14:0], sdi_sync[1]};
                            next_bits_left = bits_left - 5'h01;
                        end
                        // Output moves on the trailing edge with cke outside framed mode, else on the leading one
                        if (lead_edge != cke_eff) begin
                            next_sdo_lvl = wide ? next_shift_register[15] : next_shift_register[7];
                        end
                        if (!lead_edge && next_bits_left == 5'h00) begin
                            next_state = SPFP_IDLE;
                            rx_done = 1'b1;
                            if (!wide) begin
                                next_shift_register = {8'h00, next_shift_register[7:0]};
                            end
                        end
                    end
                end
                default: next_state = SPFP_IDLE;
            endcase
        end
    end

    // Standard buffers, overflow and status flags
    always_comb begin
        next_std_tx_full = std_tx_full;
        next_std_rx_full = std_rx_full;
        next_tx_holding_register = tx_holding_register;
        next_rx_holding_register = rx_holding_register;
        next_receive_overflow_flag = receive_overflow_flag;
        if (!enh && tx_load) begin
            next_std_tx_full = 1'b0;
        end
        if (!enh && data_wr) begin
            next_tx_holding_register = reg_wdata;
            next_std_tx_full = 1'b1;
        end
        if (!enh && data_rd) begin
            next_std_rx_full = 1'b0;
        end
        if (reg_wr && reg_addr == `SPFP_REG_STAT && !reg_wdata[`SPFP_STAT_ROV]) begin
            next_receive_overflow_flag = 1'b0;
        end
        if (rx_done) begin
            if (enh ? rxf_full : std_rx_full) begin
                next_receive_overflow_flag = 1'b1;
            end else if (!enh) begin
                next_rx_holding_register = next_shift_register;
                next_std_rx_full = 1'b1;
            end
        end
    end

    // Register writes
    always_comb begin
        next_ctl1 = ctl1;
        next_ctl2 = ctl2;
        next_port_enable = port_enable;
        next_stop_in_idle = stop_in_idle;
        next_buffer_irq_select = buffer_irq_select;
        if (reg_wr) begin
            case (reg_addr)
                `SPFP_REG_STAT: begin
                    next_port_enable = reg_wdata[`SPFP_STAT_EN];
                    next_stop_in_idle = reg_wdata[`SPFP_STAT_SIDL];
                    next_buffer_irq_select = reg_wdata[`SPFP_STAT_ISEL_LO +: 3];
                end
                `SPFP_REG_CTL1: next_ctl1 = reg_wdata & `SPFP_CTL1_MASK;
                `SPFP_REG_CTL2: next_ctl2 = reg_wdata & `SPFP_CTL2_MASK;
                default: ;
            endcase
        end
    end

    logic tx_full_flag, rx_full_flag, shifter_empty_flag, rx_fifo_empty_flag;
    logic [2:0] buffer_element_count;
    assign tx_full_flag = enh ? txf_full : std_tx_full;
    assign rx_full_flag = enh ? rxf_full : std_rx_full;
    assign shifter_empty_flag = state == SPFP_IDLE;
    assign rx_fifo_empty_flag = rxf_count == '0;
    assign buffer_element_count = master ? 3'(txf_count) : 3'(rxf_count);

    always_comb begin
        next_rd_data_q = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                `SPFP_REG_STAT: next_rd_data_q = {port_enable, 1'b0, stop_in_idle, 2'b00,
                    enh ? buffer_element_count : 3'h0, enh && shifter_empty_flag, receive_overflow_flag,
                    enh && rx_fifo_empty_flag, buffer_irq_select, tx_full_flag, rx_full_flag};
                `SPFP_REG_CTL1: next_rd_data_q = ctl1;
                `SPFP_REG_CTL2: next_rd_data_q = ctl2;
                `SPFP_REG_DATA: next_rd_data_q = enh ? rxf_head : rx_holding_register;
                default: next_rd_data_q = 16'h0000;
            endcase
        end
    end
    assign reg_rdata = rd_data_q;

    // Buffer event per interrupt select
    always_comb begin
        case (buffer_irq_select)
            3'b111: buffer_event = tx_full_flag;
            3'b110: buffer_event = load_q && txf_count == '0;
            3'b101: buffer_event = shift_done_q && txf_count == '0;
            3'b100: buffer_event = load_q;
            3'b011: buffer_event = rx_full_flag;
            3'b010: buffer_event = rxf_count >= CW'((DEPTH * 3) / 4);
            3'b001: buffer_event = !rx_fifo_empty_flag;
            3'b000: buffer_event = data_rd && rxf_count == CW'(1);
            default: buffer_event = 1'b0;
        endcase
        buffer_event = buffer_event && enh && port_enable;
    end

    // Pin drive; oe low means driven
    always_comb begin
        pins.sck_o = sck_lvl;
        pins.sck_oe_b = !(port_enable && master && !ctl1.clock_pin_disable);
        pins.sdo_o = sdo_lvl;
        pins.sdo_oe_b = !(port_enable && !ctl1.out_pin_disable);
        pins.ss_o = ctl2.frame_sync_polarity ? fs_lvl : !fs_lvl;
        pins.ss_oe_b = !(port_enable && framed && !ctl2.frame_sync_direction);
    end
    assign port_active = running;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctl1 <= `SPFP_CTL1_RESET;
            ctl2 <= `SPFP_CTL2_RESET;
            port_enable <= 1'b0;
            stop_in_idle <= 1'b0;
            buffer_irq_select <= 3'h0;
            receive_overflow_flag <= 1'b0;
            tx_holding_register <= 16'h0000;
            rx_holding_register <= 16'h0000;
            std_tx_full <= 1'b0;
            std_rx_full <= 1'b0;
            state <= SPFP_IDLE;
            shift_register <= 16'h0000;
            bits_left <= 5'h00;
            sck_lvl <= 1'b0;
            sdo_lvl <= 1'b0;
            fs_lvl <= 1'b0;
            pre_cnt <= '0;
            rd_data_q <= 16'h0000;
            shift_done_q <= 1'b0;
            load_q <= 1'b0;
        end else begin
            ctl1 <= next_ctl1;
            ctl2 <= next_ctl2;
            port_enable <= next_port_enable;
            stop_in_idle <= next_stop_in_idle;
            buffer_irq_select <= next_buffer_irq_select;
            receive_overflow_flag <= next_receive_overflow_flag;
            tx_holding_register <= next_tx_holding_register;
            rx_holding_register <= next_rx_holding_register;
            std_tx_full <= next_std_tx_full;
            std_rx_full <= next_std_rx_full;
            state <= next_state;
            shift_register <= next_shift_register;
            bits_left <= next_bits_left;
            sck_lvl <= next_sck_lvl;
            sdo_lvl <= next_sdo_lvl;
            fs_lvl <= next_fs_lvl;
            pre_cnt <= next_pre_cnt;
            rd_data_q <= next_rd_data_q;
            shift_done_q <= rx_done;
            load_q <= tx_load;
        end
    end
endmodule : spfp_core
`default_nettype wire

// File: logic/spfp_fifo.sv
// Small synchronous FIFO used for transmit and receive buffering.
// Assumes one clock; push while full and pop while empty are ignored.
`timescale 1ns/10ps
`default_nettype none
module spfp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic flush,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    input wire logic pop,
    output logic [WIDTH-1:0] head,
    output logic [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0] next_count;
    logic do_push, do_pop;

    assign head = mem[rd_ptr];

    always_comb begin
        do_push = push && (count != AW'(0) + (AW+1)'(DEPTH)) ;
        do_pop = pop && (count != '0);
        next_wr_ptr = do_push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = do_pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count + (AW+1)'(do_push) - (AW+1)'(do_pop);
        if (flush) begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
            next_count = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    always_ff @(posedge clk) begin
        if (do_push && !flush) begin
            mem[wr_ptr] <= push_data;
        end
    end
endmodule : spfp_fifo
`default_nettype wire

// File: logic/spfp_params.svh
// Constants of the framed serial port: register indices, field positions, reset values.
// Assumes inclusion by the package and the port core; definitions only.
`ifndef SPFP_PARAMS_SVH
`define SPFP_PARAMS_SVH
`define SPFP_ADDR_W 2
`define SPFP_REG_STAT 2'h0
`define SPFP_REG_CTL1 2'h1
`define SPFP_REG_CTL2 2'h2
`define SPFP_REG_DATA 2'h3
`define SPFP_STAT_EN 15
`define SPFP_STAT_SIDL 13
`define SPFP_STAT_ROV 6
`define SPFP_STAT_ISEL_LO 2
`define SPFP_CTL1_RESET 16'h0000
`define SPFP_CTL2_RESET 16'h0000
`define SPFP_CTL1_MASK 16'h1fff
`define SPFP_CTL2_MASK 16'he003
`define SPFP_FIFO_DEPTH 8
`define SPFP_PRE_W 10
`endif

// File: logic/spfp_pkg.sv
// Types of the framed serial port.
// Assumes spfp_params.svh in the include path.
`include "spfp_params.svh"
package spfp_pkg;
    typedef struct packed {
        logic [2:0] unused_hi;
        logic clock_pin_disable;
        logic out_pin_disable;
        logic word_width_select;
        logic sample_phase;
        logic clock_edge;
        logic select_pin_enable;
        logic clock_polarity;
        logic master_select;
        logic [2:0] secondary_prescale;
        logic [1:0] primary_prescale;
    } spfp_ctl1_s;
    typedef struct packed {
        logic framed_enable;
        logic frame_sync_direction;
        logic frame_sync_polarity;
        logic [10:0] unused_mid;
        logic frame_sync_edge;
        logic enhanced_buffer_enable;
    } spfp_ctl2_s;
    typedef struct packed {
        logic sck_o;
        logic sck_oe_b;
        logic sdo_o;
        logic sdo_oe_b;
        logic ss_o;
        logic ss_oe_b;
    } spfp_pins_s;
    typedef enum logic [1:0] {
        SPFP_IDLE = 2'b00,
        SPFP_SYNC = 2'b01,
        SPFP_SHIFT = 2'b10
    } spfp_state_e;
endpackage : spfp_pkg
